/* File: common/acc_pkg.sv */
package acc_pkg;
    localparam int ACC_DATA_W = 32;
    localparam int ACC_REG_W = 8;
    localparam int ACC_ADDR_MIN_W = 8;
    localparam int ACC_SYNC_STAGES = 2;

    // printed register indices; byte address is four times the index
    localparam logic [7:0] ACC_IDX_CS = 8'h2c;
    localparam logic [7:0] ACC_IDX_C0 = 8'h2d;
    localparam logic [7:0] ACC_IDX_C1 = 8'h2e;
    localparam logic [7:0] ACC_IDX_C2 = 8'h2f;
    localparam logic [7:0] ACC_IDX_IRQ_STAT = 8'h30;
    localparam logic [7:0] ACC_IDX_IRQ_MASK = 8'h31;
    localparam logic [7:0] ACC_ADDR_CS = {ACC_IDX_CS[5:0], 2'b00};
    localparam logic [7:0] ACC_ADDR_C0 = {ACC_IDX_C0[5:0], 2'b00};
    localparam logic [7:0] ACC_ADDR_C1 = {ACC_IDX_C1[5:0], 2'b00};
    localparam logic [7:0] ACC_ADDR_C2 = {ACC_IDX_C2[5:0], 2'b00};
    localparam logic [7:0] ACC_ADDR_IRQ_STAT = {ACC_IDX_IRQ_STAT[5:0], 2'b00};
    localparam logic [7:0] ACC_ADDR_IRQ_MASK = {ACC_IDX_IRQ_MASK[5:0], 2'b00};

    // control/status fields
    localparam int ACC_CS_ENABLE = 7;
    localparam int ACC_CS_HYST = 6;
    localparam int ACC_CS_FLAG = 5;
    localparam int ACC_CS_IRQ_EN = 4;
    localparam int ACC_CS_OUT = 3;
    localparam int ACC_CS_MODE_LO = 0;
    localparam int ACC_C0_PSEL_LO = 4;
    localparam int ACC_C0_NSEL_LO = 0;
    localparam int ACC_C1_LAD_EN = 7;
    localparam int ACC_C1_LAD_REF = 6;
    localparam int ACC_C1_CODE_LO = 0;
    localparam int ACC_CODE_W = 6;
    localparam int ACC_C2_INVERT = 0;
    localparam int ACC_IRQ_EVT = 0;

    localparam logic [7:0] ACC_RST_CS = 8'h00;
    localparam logic [7:0] ACC_RST_C0 = 8'h00;
    localparam logic [7:0] ACC_RST_C1 = 8'h00;
    localparam logic [7:0] ACC_RST_C2 = 8'h00;
    localparam logic [7:0] ACC_RST_IRQ = 8'h00;

    localparam logic [1:0] ACC_RESP_OKAY = 2'b00;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ACC_EDGE_FALL = 2'b00,
        ACC_EDGE_RISE = 2'b01,
        ACC_EDGE_FALL_ALT = 2'b10,
        ACC_EDGE_BOTH = 2'b11
    } acc_edge_e;

    typedef enum logic [1:0] {
        ACC_IN_EXT0 = 2'b00,
        ACC_IN_EXT1 = 2'b01,
        ACC_IN_RSVD = 2'b10,
        ACC_IN_LADDER = 2'b11
    } acc_insel_e;
endpackage

/* File: rtl/acc_sync_edge.sv */
module acc_sync_edge #(
    parameter int STAGES = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic [STAGES-1:0] sync_reg;
    logic prev_reg;

    // refused at elaboration: the shift below needs two stages at least
    if (STAGES < 2) begin : g_stages_check
        $error("acc_sync_edge needs at least two stages");
    end

    // only the last stage is ever looked at
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= {sync_reg[STAGES-2:0], i_async};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= sync_reg[STAGES-1];
        end
    end

    assign o_level = sync_reg[STAGES-1];
    assign o_rise = sync_reg[STAGES-1] & ~prev_reg;
    assign o_fall = ~sync_reg[STAGES-1] & prev_reg;
endmodule // acc_sync_edge

/* File: rtl/acc_comparator_ctrl.sv */
module acc_comparator_ctrl
    import acc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [acc_pkg::ACC_DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [acc_pkg::ACC_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_cmp_raw,
    input wire logic i_wait_mode,
    input wire logic i_deep_stop_mode,
    input wire logic i_debug_mode,
    output logic o_cmp_enable,
    output logic o_hyst_sel,
    output logic [1:0] o_cmp_positive_select,
    output logic [1:0] o_cmp_negative_select,
    output logic o_ladder_enable,
    output logic o_ladder_ref_sel,
    output logic [acc_pkg::ACC_CODE_W-1:0] o_ladder_code,
    output logic o_cmp_invert,
    output logic o_irq,
    output logic o_wake_req
);
    import acc_pkg::*;

    logic [ACC_REG_W-1:0] cs_reg;
    logic [ACC_REG_W-1:0] c0_reg;
    logic [ACC_REG_W-1:0] c1_reg;
    logic [ACC_REG_W-1:0] c2_reg;
    logic irq_stat_reg;
    logic irq_mask_reg;
    logic out_reg;
    logic en_d_reg;
    logic [7:0] aw_addr_reg;
    logic aw_have_reg;
    logic [7:0] w_data_reg;
    logic w_lane_reg;
    logic w_have_reg;
    logic aw_have_next;
    logic w_have_next;
    logic wr_do;
    logic rd_take;
    logic rvalid_next;
    logic cmp_level;
    logic cmp_rise;
    logic cmp_fall;
    logic cmp_event;
    logic cs_write;
    logic flag_next;
    logic irq_next;

    // refused at elaboration: decoding looks at the low eight address bits
    if (ADDR_W < ACC_ADDR_MIN_W) begin : g_addr_check
        $error("ADDR_W too narrow for the register map");
    end

    function automatic logic addr_mapped(input logic [7:0] a);
        return a == ACC_ADDR_CS || a == ACC_ADDR_C0 || a == ACC_ADDR_C1
            || a == ACC_ADDR_C2 || a == ACC_ADDR_IRQ_STAT
            || a == ACC_ADDR_IRQ_MASK;
    endfunction

    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic rise,
                                      input logic fall);
        logic hit;
        hit = 1'b0;
        case (acc_edge_e'(mode))
            ACC_EDGE_FALL: hit = fall;
            ACC_EDGE_RISE: hit = rise;
            ACC_EDGE_FALL_ALT: hit = fall;
            ACC_EDGE_BOTH: hit = rise | fall;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // raw comparator output is asynchronous to the bus clock
    acc_sync_edge #(
        .STAGES(ACC_SYNC_STAGES)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async(i_cmp_raw),
        .o_level(cmp_level),
        .o_rise(cmp_rise),
        .o_fall(cmp_fall)
    );

    // inversion swaps the edge sense; edges in the first enabled cycle are ignored,
    // but an edge the analog side makes on turning on arrives later and still counts
    assign cmp_event = cs_reg[ACC_CS_ENABLE] & en_d_reg
        & edge_hit(cs_reg[ACC_CS_MODE_LO +: 2],
                   c2_reg[ACC_C2_INVERT] ? cmp_fall : cmp_rise,
                   c2_reg[ACC_C2_INVERT] ? cmp_rise : cmp_fall);

    // ---------------- write channel ----------------
    assign wr_do = aw_have_reg & w_have_reg & ~o_bvalid;
    assign aw_have_next = (i_awvalid & o_awready) | (aw_have_reg & ~wr_do);
    assign w_have_next = (i_wvalid & o_wready) | (w_have_reg & ~wr_do);
    assign cs_write = wr_do & w_lane_reg & (aw_addr_reg == ACC_ADDR_CS);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            o_awready <= ~aw_have_next;
            o_wready <= ~w_have_next;
            if (i_awvalid && o_awready) begin
                aw_addr_reg <= i_awaddr[7:0];
            end
            if (i_wvalid && o_wready) begin
                w_data_reg <= i_wdata[ACC_REG_W-1:0];
                w_lane_reg <= i_wstrb[0];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_bvalid <= 1'b0;
            o_bresp <= ACC_RESP_OKAY;
        end else if (wr_do) begin
            o_bvalid <= 1'b1;
            o_bresp <= addr_mapped(aw_addr_reg) ? ACC_RESP_OKAY
                                                : ACC_RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // ---------------- settings ----------------
    // deep stop and debug do not gate anything: settings only change by a
    // bus write or the system reset
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            c0_reg <= ACC_RST_C0;
            c1_reg <= ACC_RST_C1;
            c2_reg <= ACC_RST_C2;
            irq_mask_reg <= ACC_RST_IRQ[ACC_IRQ_EVT];
        end else if (wr_do && w_lane_reg) begin
            case (aw_addr_reg)
                ACC_ADDR_C0: begin
                    c0_reg <= w_data_reg & 8'h33;
                end
                ACC_ADDR_C1: c1_reg <= w_data_reg;
                ACC_ADDR_C2: c2_reg <= {7'h00, w_data_reg[ACC_C2_INVERT]};
                ACC_ADDR_IRQ_MASK: irq_mask_reg <= w_data_reg[ACC_IRQ_EVT];
                default: ;
            endcase
        end
    end

    // set wins over a clearing write in the same cycle
    assign flag_next = cmp_event
        | (cs_reg[ACC_CS_FLAG] & ~(cs_write & ~w_data_reg[ACC_CS_FLAG]));

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cs_reg <= ACC_RST_CS;
        end else begin
            cs_reg[ACC_CS_FLAG] <= flag_next;
            cs_reg[ACC_CS_OUT] <= 1'b0;
            cs_reg[2] <= 1'b0;
            if (cs_write) begin
                cs_reg[ACC_CS_ENABLE] <= w_data_reg[ACC_CS_ENABLE];
                cs_reg[ACC_CS_HYST] <= w_data_reg[ACC_CS_HYST];
                cs_reg[ACC_CS_IRQ_EN] <= w_data_reg[ACC_CS_IRQ_EN];
                cs_reg[ACC_CS_MODE_LO +: 2] <= w_data_reg[ACC_CS_MODE_LO +: 2];
            end
        end
    end

    // live result, forced low while disabled
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            out_reg <= 1'b0;
            en_d_reg <= 1'b0;
        end else begin
            out_reg <= cs_reg[ACC_CS_ENABLE]
                & (cmp_level ^ c2_reg[ACC_C2_INVERT]);
            en_d_reg <= cs_reg[ACC_CS_ENABLE];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            irq_stat_reg <= ACC_RST_IRQ[ACC_IRQ_EVT];
        end else begin
            irq_stat_reg <= cmp_event | (irq_stat_reg & ~(wr_do & w_lane_reg
                & aw_addr_reg == ACC_ADDR_IRQ_STAT & w_data_reg[ACC_IRQ_EVT]));
        end
    end

    // ---------------- interrupt, wake request and outputs toward the analog side ----------------
    assign irq_next = (cs_reg[ACC_CS_FLAG] & cs_reg[ACC_CS_IRQ_EN])
        | (irq_stat_reg & irq_mask_reg);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
            o_wake_req <= 1'b0;
        end else begin
            o_irq <= irq_next;
            // the wake request only leaves in a low-power mode
            o_wake_req <= irq_next & (i_wait_mode | i_deep_stop_mode);
        end
    end

    // the whole path keeps running in wait, deep stop and debug
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_cmp_enable <= 1'b0;
            o_hyst_sel <= 1'b0;
            o_cmp_positive_select <= ACC_IN_EXT0;
            o_cmp_negative_select <= ACC_IN_EXT0;
            o_ladder_enable <= 1'b0;
            o_ladder_ref_sel <= 1'b0;
            o_ladder_code <= '0;
            o_cmp_invert <= 1'b0;
        end else begin
            o_cmp_enable <= cs_reg[ACC_CS_ENABLE];
            o_hyst_sel <= cs_reg[ACC_CS_HYST];
            o_cmp_positive_select <= c0_reg[ACC_C0_PSEL_LO +: 2];
            o_cmp_negative_select <= c0_reg[ACC_C0_NSEL_LO +: 2];
            o_ladder_enable <= c1_reg[ACC_C1_LAD_EN];
            o_ladder_ref_sel <= c1_reg[ACC_C1_LAD_REF];
            o_ladder_code <= c1_reg[ACC_C1_CODE_LO +: ACC_CODE_W];
            o_cmp_invert <= c2_reg[ACC_C2_INVERT];
        end
    end

    // ---------------- read channel ----------------
    assign rd_take = i_arvalid & o_arready;
    assign rvalid_next = rd_take | (o_rvalid & ~i_rready);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= ACC_RESP_OKAY;
        end else begin
            o_arready <= ~rvalid_next;
            o_rvalid <= rvalid_next;
            if (rd_take) begin
                o_rresp <= addr_mapped(i_araddr[7:0]) ? ACC_RESP_OKAY
                                                      : ACC_RESP_SLVERR;
                case (i_araddr[7:0])
                    ACC_ADDR_CS: o_rdata <= {24'h000000,
                        cs_reg[7:4], out_reg, 1'b0, cs_reg[1:0]};
                    ACC_ADDR_C0: o_rdata <= {24'h000000, c0_reg};
                    ACC_ADDR_C1: o_rdata <= {24'h000000, c1_reg};
                    ACC_ADDR_C2: o_rdata <= {24'h000000, c2_reg};
                    ACC_ADDR_IRQ_STAT: o_rdata <= {31'h00000000, irq_stat_reg};
                    ACC_ADDR_IRQ_MASK: o_rdata <= {31'h00000000, irq_mask_reg};
                    default: o_rdata <= '0;
                endcase
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_clear_write;
        cs_write && !w_data_reg[ACC_CS_FLAG];
    endsequence

    property p_flag_set;
        cmp_event |=> cs_reg[ACC_CS_FLAG];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set by qualifying edge");

    property p_flag_clear;
        s_clear_write ##0 !cmp_event |=> !cs_reg[ACC_CS_FLAG];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("writing 0 did not clear flag");

    property p_flag_write_one;
        !cs_reg[ACC_CS_FLAG] && !cmp_event |=> !cs_reg[ACC_CS_FLAG];
    endproperty
    a_flag_write_one: assert property (p_flag_write_one)
        else $error("flag set without an edge");

    property p_rise_only;
        cs_reg[ACC_CS_MODE_LO +: 2] == ACC_EDGE_RISE && !cs_reg[ACC_CS_FLAG]
            && !(c2_reg[ACC_C2_INVERT] ? cmp_fall : cmp_rise)
            |=> !cs_reg[ACC_CS_FLAG];
    endproperty
    a_rise_only: assert property (p_rise_only)
        else $error("rising mode flagged another edge");

    property p_irq_follows;
        cs_reg[ACC_CS_FLAG] && cs_reg[ACC_CS_IRQ_EN] |=> o_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("irq not raised for enabled flag");

    property p_irq_drops;
        !irq_next |=> !o_irq;
    endproperty
    a_irq_drops: assert property (p_irq_drops)
        else $error("irq high without cause");

    property p_out_disabled;
        !cs_reg[ACC_CS_ENABLE] |=> !out_reg;
    endproperty
    a_out_disabled: assert property (p_out_disabled)
        else $error("output status set while disabled");

    sequence s_stop_hold;
        i_deep_stop_mode && !wr_do;
    endsequence

    property p_stop_keeps;
        s_stop_hold |=> $stable(c0_reg) && $stable(c1_reg) && $stable(c2_reg);
    endproperty
    a_stop_keeps: assert property (p_stop_keeps)
        else $error("settings changed in deep stop");

    property p_wake;
        irq_next && (i_wait_mode || i_deep_stop_mode) |=> o_wake_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake request for pending irq");

    property p_debug_runs;
        i_debug_mode && cmp_event |=> cs_reg[ACC_CS_FLAG] ##1 o_irq
            || !cs_reg[ACC_CS_IRQ_EN];
    endproperty
    a_debug_runs: assert property (p_debug_runs)
        else $error("comparator stalled in debug mode");

    property p_reset_defaults;
        @(posedge i_ref_clk) disable iff (1'b0)
            i_rst |=> cs_reg == ACC_RST_CS
            && c0_reg == ACC_RST_C0 && c1_reg == ACC_RST_C1;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("settings not returned to reset values");
endmodule // acc_comparator_ctrl

/* File: dv/acc_analog_model.sv */
module acc_analog_model #(
    parameter int SUPPLY_FS = 256,
    parameter int BANDGAP_FS = 128
) (
    input wire logic i_cmp_enable,
    input wire logic [1:0] i_pos_sel,
    input wire logic [1:0] i_neg_sel,
    input wire logic i_ladder_enable,
    input wire logic i_ladder_ref_sel,
    input wire logic [5:0] i_ladder_code,
    input wire logic [7:0] i_ext0,
    input wire logic [7:0] i_ext1,
    output logic o_cmp_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    int ladder;
    logic raw_now;

    // code 63 gives the full reference, code 0 one 64th of it
    always_comb begin
        ladder = 0;
        if (i_ladder_enable) begin
            ladder = (i_ladder_ref_sel ? BANDGAP_FS : SUPPLY_FS)
                * (int'(i_ladder_code) + 1) / 64;
        end
    end

    // reserved code feeds ground
    // everything read comes in as an argument so the process wakes on it
    function automatic int pick(input logic [1:0] s, input int lad,
                                input logic [7:0] e0, input logic [7:0] e1);
        case (s)
            2'b00: pick = int'(e0);
            2'b01: pick = int'(e1);
            2'b11: pick = lad;
            default: pick = 0;
        endcase
    endfunction

    always_comb begin
        raw_now = i_cmp_enable
            && (pick(i_pos_sel, ladder, i_ext0, i_ext1)
                > pick(i_neg_sel, ladder, i_ext0, i_ext1));
    end

    // output moves off the clock edge, as an analog result would
    assign #1 o_cmp_raw = raw_now;
endmodule // acc_analog_model

/* File: dv/acc_comparator_ctrl_test.sv */
module acc_comparator_ctrl_test import acc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'h0;
    logic i_wait_mode = 1'b0, i_deep_stop_mode = 1'b0;
    logic i_debug_mode = 1'b0;
    logic [7:0] ext0 = 8'h32, ext1 = 8'h00;
    logic i_cmp_raw, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    logic [1:0] o_cmp_positive_select, o_cmp_negative_select;
    logic [31:0] o_rdata;
    logic o_cmp_enable, o_hyst_sel, o_ladder_enable, o_ladder_ref_sel;
    logic [5:0] o_ladder_code;
    logic o_cmp_invert, o_irq, o_wake_req;
    int n_errors = 0, n_compared = 0, cycles = 0;

    always #2 i_ref_clk = ~i_ref_clk;

    acc_comparator_ctrl DUT (
        .i_ref_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
        .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
        .o_rresp, .o_rvalid, .i_rready, .i_cmp_raw, .i_wait_mode,
        .i_deep_stop_mode, .i_debug_mode, .o_cmp_enable, .o_hyst_sel,
        .o_cmp_positive_select, .o_cmp_negative_select,
        .o_ladder_enable, .o_ladder_ref_sel, .o_ladder_code,
        .o_cmp_invert, .o_irq, .o_wake_req
    );

    acc_analog_model u_model (
        .i_cmp_enable(o_cmp_enable), .i_pos_sel(o_cmp_positive_select),
        .i_neg_sel(o_cmp_negative_select),
        .i_ladder_enable(o_ladder_enable),
        .i_ladder_ref_sel(o_ladder_ref_sel), .i_ladder_code(o_ladder_code),
        .i_ext0(ext0), .i_ext1(ext1), .o_cmp_raw(i_cmp_raw)
    );

    task automatic finish_test();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // generous ceiling; the whole run needs well under a thousand cycles
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er = ACC_RESP_OKAY,
                      input logic [3:0] st = 4'hf);
        logic done;
        done = 1'b0;
        @(posedge i_ref_clk);
        i_awaddr <= a;
        i_awvalid <= 1'b1;
        i_wdata <= {24'h0, d};
        i_wstrb <= st;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        while (!done) begin
            @(posedge i_ref_clk);
            if (i_awvalid && o_awready === 1'b1)
                i_awvalid <= 1'b0;
            if (i_wvalid && o_wready === 1'b1)
                i_wvalid <= 1'b0;
            if (o_bvalid === 1'b1) begin
                chk("bresp", 32'(er), 32'(o_bresp));
                i_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string nm,
                      input logic [1:0] er = ACC_RESP_OKAY);
        logic done;
        done = 1'b0;
        @(posedge i_ref_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        while (!done) begin
            @(posedge i_ref_clk);
            if (i_arvalid && o_arready === 1'b1)
                i_arvalid <= 1'b0;
            if (o_rvalid === 1'b1) begin
                chk(nm, e, o_rdata & m);
                chk("rresp", 32'(er), 32'(o_rresp));
                i_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // the flag needs three edges after a change, so allow eight
    task automatic set_in(input logic [7:0] v);
        @(posedge i_ref_clk);
        ext0 <= v;
        tick(8);
    endtask

    task automatic regs0();
        logic [7:0] ad [6];
        ad = '{ACC_ADDR_CS, ACC_ADDR_C0, ACC_ADDR_C1, ACC_ADDR_C2,
               ACC_ADDR_IRQ_STAT, ACC_ADDR_IRQ_MASK};
        foreach (ad[i]) rd(ad[i], 32'hffffffff, 32'h0, "reset value");
    endtask

    task automatic t_reset();
        regs0();
        rd(8'h00, 32'hffffffff, 32'h0, "unmapped", ACC_RESP_SLVERR);
        wr(8'h00, 8'hff, ACC_RESP_SLVERR);
        // low lane strobe off: answered but nothing stored
        wr(ACC_ADDR_C2, 8'h01, ACC_RESP_OKAY, 4'he);
        rd(ACC_ADDR_C2, 32'hffffffff, 32'h0, "no lane write");
        $display("reset test done");
    endtask

    task automatic t_config();
        wr(ACC_ADDR_C0, 8'hff);
        rd(ACC_ADDR_C0, 32'hffffffff, 32'h33, "c0");
        for (int s = 0; s < 4; s++) begin
            wr(ACC_ADDR_C0, {2'b00, 2'(s), 2'b00, 2'(s)});
            // outputs follow the register one edge after the answer
            tick(1);
            chk("psel", 32'(s), 32'(o_cmp_positive_select));
            chk("nsel", 32'(s), 32'(o_cmp_negative_select));
        end
        wr(ACC_ADDR_C1, 8'hff);
        tick(1);
        chk("ladder", 32'h1ff, {23'h0, o_ladder_enable, o_ladder_ref_sel,
            1'b1, o_ladder_code});
        wr(ACC_ADDR_CS, 8'h40);
        tick(1);
        chk("hyst", 32'h1, 32'(o_hyst_sel));
        wr(ACC_ADDR_CS, 8'h00);
        wr(ACC_ADDR_C2, 8'hff);
        rd(ACC_ADDR_C2, 32'hffffffff, 32'h01, "c2");
        chk("invert", 32'h1, 32'(o_cmp_invert));
        wr(ACC_ADDR_C2, 8'h00);
        wr(ACC_ADDR_C1, 8'h00);
        $display("config test done");
    endtask

    task automatic t_ladder();
        logic [7:0] c1 [5];
        logic e [5];
        c1 = '{8'h80, 8'ha2, 8'ha3, 8'hbf, 8'hff};
        e = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        wr(ACC_ADDR_C0, 8'h03);
        wr(ACC_ADDR_CS, 8'h80);
        set_in(8'h90);
        foreach (c1[i]) begin
            wr(ACC_ADDR_C1, c1[i]);
            tick(6);
            rd(ACC_ADDR_CS, 32'h08, {28'h0, e[i], 3'h0},
                "status");
        end
        wr(ACC_ADDR_CS, 8'h00);
        tick(4);
        rd(ACC_ADDR_CS, 32'hff, 32'h00, "off status");
        set_in(8'h32);
        $display("ladder test done");
    endtask

    task automatic t_edges();
        logic [7:0] base;
        wr(ACC_ADDR_C1, 8'h9f);
        for (int i = 0; i < 4; i++) begin
            base = 8'h80 | 8'(i);
            wr(ACC_ADDR_CS, base);
            wr(ACC_ADDR_CS, base | 8'h20);
            set_in(8'hc8);
            rd(ACC_ADDR_CS, 32'hff, 32'(base | 8'h08 | (i % 2 == 1 ? 8'h20
                : 8'h00)), "flag rise");
            wr(ACC_ADDR_CS, base);
            set_in(8'h32);
            rd(ACC_ADDR_CS, 32'hff, 32'(base | (i == 1 ? 8'h00 : 8'h20)),
                "flag fall");
        end
        $display("edge test done");
    endtask

    task automatic t_invert();
        wr(ACC_ADDR_CS, 8'h81);
        wr(ACC_ADDR_C2, 8'h01);
        tick(6);
        wr(ACC_ADDR_CS, 8'h81);
        rd(ACC_ADDR_CS, 32'hff, 32'h89, "inverted level");
        set_in(8'hc8);
        rd(ACC_ADDR_CS, 32'hff, 32'h81, "inverted fall");
        set_in(8'h32);
        rd(ACC_ADDR_CS, 32'hff, 32'ha9, "inverted rise");
        wr(ACC_ADDR_C2, 8'h00);
        $display("invert test done");
    endtask

    task automatic t_irq();
        wr(ACC_ADDR_CS, 8'h93);
        i_wait_mode <= 1'b1;
        set_in(8'hc8);
        chk("irq wait", 32'h1, 32'(o_irq));
        chk("wake wait", 32'h1, 32'(o_wake_req));
        wr(ACC_ADDR_CS, 8'ha3);
        tick(2);
        chk("irq disabled", 32'h0, 32'(o_irq));
        i_wait_mode <= 1'b0;
        wr(ACC_ADDR_CS, 8'h83);
        wr(ACC_ADDR_IRQ_STAT, 8'h01);
        wr(ACC_ADDR_IRQ_MASK, 8'h01);
        set_in(8'h32);
        chk("irq unmasked", 32'h1, 32'(o_irq));
        chk("wake run", 32'h0, 32'(o_wake_req));
        wr(ACC_ADDR_IRQ_MASK, 8'h00);
        tick(2);
        chk("irq masked", 32'h0, 32'(o_irq));
        rd(ACC_ADDR_IRQ_STAT, 32'hff, 32'h01, "stat set");
        wr(ACC_ADDR_IRQ_MASK, 8'h01);
        wr(ACC_ADDR_IRQ_STAT, 8'h01);
        tick(2);
        chk("irq cleared", 32'h0, 32'(o_irq));
        rd(ACC_ADDR_IRQ_STAT, 32'hff, 32'h00, "stat clear");
        i_deep_stop_mode <= 1'b1;
        i_debug_mode <= 1'b1;
        wr(ACC_ADDR_CS, 8'h93);
        set_in(8'hc8);
        chk("irq stop", 32'h1, 32'(o_irq));
        chk("wake stop", 32'h1, 32'(o_wake_req));
        i_deep_stop_mode <= 1'b0;
        rd(ACC_ADDR_CS, 32'hff, 32'hbb, "cs kept");
        rd(ACC_ADDR_C1, 32'hff, 32'h9f, "c1 kept");
        rd(ACC_ADDR_C0, 32'hff, 32'h03, "c0 kept");
        i_deep_stop_mode <= 1'b1;
        i_rst <= 1'b1;
        tick(3);
        i_rst <= 1'b0;
        i_deep_stop_mode <= 1'b0;
        tick(2);
        regs0();
        chk("irq after reset", 32'h0, 32'(o_irq));
        $display("interrupt test done");
    endtask

    initial begin
        tick(16);
        i_rst <= 1'b0;
        tick(2);
        t_reset();
        t_config();
        t_ladder();
        t_edges();
        t_invert();
        t_irq();
        finish_test();
    end
endmodule // acc_comparator_ctrl_test
